/* File: inc/tpfs_pkg.sv */
// Purpose: Constants for the timer pin function select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Not every printed offset is a multiple of four, so offsets are register indices

package tpfs_pkg;
    localparam int          ADDR_W           = 12;
    // Register indices (byte address is four times the index)
    localparam logic [11:0] IDX_THREE_PHASE  = 12'h348;
    localparam logic [11:0] IDX_TRIG_SEL     = 12'h383;
    localparam logic [11:0] IDX_UPDOWN       = 12'h384;
    localparam logic [11:0] IDX_TMR_TWO_MODE = 12'h398;
    localparam logic [11:0] IDX_TMR_THR_MODE = 12'h399;
    localparam logic [11:0] IDX_PORT_DIR     = 12'h3ef;
    localparam logic [11:0] IDX_PULLUP_ONE   = 12'h3fd;
    localparam logic [11:0] IDX_PIN_STATUS   = 12'h3f0;
    localparam logic [7:0]  RESET_VAL        = 8'h00;
    // Field positions
    localparam int          BIT_THREE_PHASE  = 2;
    localparam int          BIT_TRIG_TWO_HI  = 3;
    localparam int          BIT_TRIG_TWO_LO  = 2;
    localparam int          BIT_TWO_PHASE_3  = 6;
    localparam int          BIT_TWO_PHASE_2  = 5;
    localparam int          BIT_MODE_GATE    = 4;
    localparam int          BIT_MODE_PULSE   = 2;
    localparam int          BIT_PULLUP_GRP   = 7;
    localparam int          BIT_DIR_SIX      = 6;
    localparam int          BIT_DIR_FIVE     = 5;
    localparam int          BIT_DIR_FOUR     = 4;
endpackage

/* File: inc/tpfs_pin_if.sv */
// Purpose: Carries one output-capable pin's controls to its selector
// Assumes: Single clock domain
// Notes:   Port-side and timer-side signals grouped

`timescale 1ns/1ps
interface tpfs_pin_if;
    logic dir;
    logic mode_gate;
    logic mode_pulse;
    logic two_phase;
    logic three_phase;
    logic port_data;
    logic pulse;
    logic w_phase;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic updown_in;
    logic two_phase_in;
    logic port_in;
    modport ctrl (output dir, mode_gate, mode_pulse, two_phase, three_phase, port_data, pulse, w_phase,
                  pin_in, input pin_out, pin_oe, updown_in, two_phase_in, port_in);
    modport sel (input dir, mode_gate, mode_pulse, two_phase, three_phase, port_data, pulse, w_phase,
                 pin_in, output pin_out, pin_oe, updown_in, two_phase_in, port_in);
endinterface

/* File: verilog/tpfs_out_sel.sv */
// Purpose: Function select for one timer output pin
// Assumes: pin_in already synchronised
// Notes:   Purely combinational

`timescale 1ns/1ps
module tpfs_out_sel (
    tpfs_pin_if.sel p
);
    wire three_on   = p.three_phase;
    wire pulse_on   = !three_on && p.mode_pulse && !p.two_phase;
    wire input_mode = !three_on && !p.dir && !p.mode_pulse;
    wire port_out   = !three_on && !pulse_on && p.dir;
    assign p.pin_oe       = three_on || pulse_on || port_out;
    assign p.pin_out      = three_on ? p.w_phase : (pulse_on ? p.pulse : p.port_data);
    assign p.updown_in    = input_mode && p.mode_gate && !p.two_phase && p.pin_in;
    assign p.two_phase_in = input_mode && p.mode_gate && p.two_phase && p.pin_in;
    assign p.port_in      = p.pin_in;
endmodule // tpfs_out_sel

/* File: verilog/tpfs_top.sv */
// Purpose: Pin function select for three shared port-seven pins
// Assumes: APB slave, zero wait states, one clock
// Notes:   Timer counting lives elsewhere; this only steers pins

`timescale 1ns/1ps
module tpfs_top (
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tpfs_pkg::ADDR_W+1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [7:0]                  port_data,
    input  wire logic                        timer_two_pulse,
    input  wire logic                        timer_three_pulse,
    input  wire logic                        w_phase,
    input  wire logic                        w_phase_n,
    input  wire logic [2:0]                  pin_in,
    output logic      [2:0]                  pin_out,
    output logic      [2:0]                  pin_oe,
    output logic      [2:0]                  pin_pullup,
    output logic                             timer_three_updown,
    output logic                             timer_three_two_phase,
    output logic                             timer_two_updown,
    output logic                             timer_two_two_phase,
    output logic                             timer_two_gate,
    output logic                             timer_two_count_src,
    output logic                             timer_two_trigger,
    output logic      [2:0]                  port_pin_in
);
    import tpfs_pkg::*;

    // pin index 0 = port_seven_bit_four, 1 = bit_five, 2 = bit_six
    logic [7:0]  three_phase_control;
    logic [7:0]  timer_trigger_select;
    logic [7:0]  updown_flag_control;
    logic [7:0]  timer_two_mode;
    logic [7:0]  timer_three_mode;
    logic [7:0]  port_seven_direction;
    logic [7:0]  pullup_control_one;
    logic [2:0]  pin_meta;
    logic [2:0]  pin_sync;
    logic [31:0] next_prdata;

    wire [ADDR_W-1:0] idx      = paddr[ADDR_W+1:2];
    wire              wr_fire  = psel && penable && pwrite;
    wire              rd_setup = psel && !penable && !pwrite;
    wire hit_tp = idx == IDX_THREE_PHASE;
    wire hit_ts = idx == IDX_TRIG_SEL;
    wire hit_ud = idx == IDX_UPDOWN;
    wire hit_m2 = idx == IDX_TMR_TWO_MODE;
    wire hit_m3 = idx == IDX_TMR_THR_MODE;
    wire hit_dr = idx == IDX_PORT_DIR;
    wire hit_pu = idx == IDX_PULLUP_ONE;
    wire hit_st = idx == IDX_PIN_STATUS;
    wire mapped = hit_tp | hit_ts | hit_ud | hit_m2 | hit_m3 | hit_dr | hit_pu | hit_st;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Index constants are 12 bits wide; any other width would alias registers
    if (ADDR_W != 12) begin : g_addr_w_check
        $error("register index width must be 12");
    end

    // One enable per register keeps each flop block trivial
    wire we_tp = wr_fire && hit_tp;
    wire we_ts = wr_fire && hit_ts;
    wire we_ud = wr_fire && hit_ud;
    wire we_m2 = wr_fire && hit_m2;
    wire we_m3 = wr_fire && hit_m3;
    wire we_dr = wr_fire && hit_dr;
    wire we_pu = wr_fire && hit_pu;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            three_phase_control <= RESET_VAL;
        end else if (we_tp) begin
            three_phase_control <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_trigger_select <= RESET_VAL;
        end else if (we_ts) begin
            timer_trigger_select <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            updown_flag_control <= RESET_VAL;
        end else if (we_ud) begin
            updown_flag_control <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_two_mode <= RESET_VAL;
        end else if (we_m2) begin
            timer_two_mode <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timer_three_mode <= RESET_VAL;
        end else if (we_m3) begin
            timer_three_mode <= pwdata[7:0];
        end
    end

    // Direction bits cleared at reset so no pin drives before software asks
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            port_seven_direction <= RESET_VAL;
        end else if (we_dr) begin
            port_seven_direction <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pullup_control_one <= RESET_VAL;
        end else if (we_pu) begin
            pullup_control_one <= pwdata[7:0];
        end
    end

    // Pins are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Status shows synchronised pin levels and live drive enables
    assign next_prdata = hit_tp ? {24'h000000, three_phase_control}  :
                         hit_ts ? {24'h000000, timer_trigger_select} :
                         hit_ud ? {24'h000000, updown_flag_control}  :
                         hit_m2 ? {24'h000000, timer_two_mode}       :
                         hit_m3 ? {24'h000000, timer_three_mode}     :
                         hit_dr ? {24'h000000, port_seven_direction} :
                         hit_pu ? {24'h000000, pullup_control_one}   :
                         hit_st ? {24'h000000, 1'b0, pin_oe, 1'b0, pin_sync} : 32'h00000000;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            prdata <= 32'h00000000;
        else if (rd_setup)
            prdata <= next_prdata;
    end

    wire three_on = three_phase_control[BIT_THREE_PHASE];
    wire grp_pu   = pullup_control_one[BIT_PULLUP_GRP];

    tpfs_pin_if p6 ();
    tpfs_pin_if p4 ();

    assign p6.dir         = port_seven_direction[BIT_DIR_SIX];
    assign p6.mode_gate   = timer_three_mode[BIT_MODE_GATE];
    assign p6.mode_pulse  = timer_three_mode[BIT_MODE_PULSE];
    assign p6.two_phase   = updown_flag_control[BIT_TWO_PHASE_3];
    assign p6.three_phase = 1'b0;
    assign p6.port_data   = port_data[6];
    assign p6.pulse       = timer_three_pulse;
    assign p6.w_phase     = 1'b0;
    assign p6.pin_in      = pin_sync[2];

    assign p4.dir         = port_seven_direction[BIT_DIR_FOUR];
    assign p4.mode_gate   = timer_two_mode[BIT_MODE_GATE];
    assign p4.mode_pulse  = timer_two_mode[BIT_MODE_PULSE];
    assign p4.two_phase   = updown_flag_control[BIT_TWO_PHASE_2];
    assign p4.three_phase = three_on;
    assign p4.port_data   = port_data[4];
    assign p4.pulse       = timer_two_pulse;
    assign p4.w_phase     = w_phase;
    assign p4.pin_in      = pin_sync[0];

    tpfs_out_sel u_sel_six (
        .p (p6.sel)
    );

    tpfs_out_sel u_sel_four (
        .p (p4.sel)
    );

    // Timer input pin (bit five): inverted W phase when three-phase mode is on
    wire p5_dir    = port_seven_direction[BIT_DIR_FIVE];
    wire trig_zero = !timer_trigger_select[BIT_TRIG_TWO_HI] && !timer_trigger_select[BIT_TRIG_TWO_LO];
    wire p5_timer  = !p5_dir && trig_zero && !three_on;
    wire p5_w_out  = three_on;
    wire p5_oe     = p5_w_out || p5_dir;

    assign pin_out    = {p6.pin_out, p5_w_out ? w_phase_n : port_data[5], p4.pin_out};
    assign pin_oe     = {p6.pin_oe, p5_oe, p4.pin_oe};
    // Pull-up only on a pin that is not driven, whether a port input or a timer input
    assign pin_pullup = {grp_pu && !p6.pin_oe, grp_pu && !p5_oe, grp_pu && !p4.pin_oe};

    assign timer_three_updown    = p6.updown_in;
    assign timer_three_two_phase = p6.two_phase_in;
    assign timer_two_updown      = p4.updown_in;
    assign timer_two_two_phase   = p4.two_phase_in;
    assign timer_two_count_src   = p5_timer && pin_sync[1];
    assign timer_two_gate        = p5_timer && timer_two_mode[BIT_MODE_GATE] && pin_sync[1];
    assign timer_two_trigger     = p5_timer && timer_two_mode[BIT_MODE_GATE] && pin_sync[1];
    assign port_pin_in           = {p6.port_in, pin_sync[1], p4.port_in};
endmodule // tpfs_top

/* File: test/tpfs_pin_model.sv */
// Purpose: Pin partner: loads and sources on the three shared pins
// Assumes: Driven pins follow the block; others take the source or pull
// Notes:   A floating pin toggles so a stale level never passes
`timescale 1ns/1ps
module tpfs_pin_model (
    input  wire logic       core_clk,
    input  wire logic [2:0] pin_out,
    input  wire logic [2:0] pin_oe,
    input  wire logic [2:0] pin_pullup,
    input  wire logic [2:0] ext,
    input  wire logic       ext_en,
    output logic      [2:0] pin_in
);
    logic [2:0] flip = 3'h0;
    always @(posedge core_clk) begin
        flip <= ~flip;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_en ? ext : (pin_pullup | flip)));
endmodule // tpfs_pin_model

/* File: test/tpfs_top_assertions.sv */
// Purpose: Port-level checks of pin function selection
// Assumes: Register shadows follow completed APB writes
// Notes:   Pin-derived outputs checked once the synchroniser has filled
`timescale 1ns/1ps
module tpfs_top_assertions
    import tpfs_pkg::*;
(
    input wire logic                core_clk,
    input wire logic                resetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W+1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic [7:0]          port_data,
    input wire logic                timer_three_pulse,
    input wire logic                w_phase,
    input wire logic [2:0]          pin_in,
    input wire logic [2:0]          pin_out,
    input wire logic [2:0]          pin_oe,
    input wire logic [2:0]          pin_pullup,
    input wire logic                timer_three_updown,
    input wire logic                timer_three_two_phase,
    input wire logic                timer_two_gate,
    input wire logic                timer_two_count_src,
    input wire logic [2:0]          port_pin_in
);
    logic [7:0] tp, ts, ud, m2, m3, dr, pu;
    logic [1:0] fill;
    wire        wr = psel & penable & pwrite & pready;
    wire [11:0] ix = paddr[ADDR_W+1:2];
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            {tp, ts, ud, m2, m3, dr, pu} <= '0;
            fill <= 2'h0;
        end else begin
            if (fill != 2'h3) fill <= fill + 2'h1;
            if (wr && ix == IDX_THREE_PHASE) tp <= pwdata[7:0];
            if (wr && ix == IDX_TRIG_SEL) ts <= pwdata[7:0];
            if (wr && ix == IDX_UPDOWN) ud <= pwdata[7:0];
            if (wr && ix == IDX_TMR_TWO_MODE) m2 <= pwdata[7:0];
            if (wr && ix == IDX_TMR_THR_MODE) m3 <= pwdata[7:0];
            if (wr && ix == IDX_PORT_DIR) dr <= pwdata[7:0];
            if (wr && ix == IDX_PULLUP_ONE) pu <= pwdata[7:0];
        end
    end
    wire ok = fill == 2'h3;
    wire p3 = m3[2] & ~ud[6];
    wire i3 = ~dr[6] & m3[4] & ~m3[2];
    wire g  = ~dr[5] & ~ts[3] & ~ts[2] & ~tp[2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_oe_six; pin_oe[2] == (p3 | dr[6]); endproperty
    property p_out_six; pin_oe[2] |-> pin_out[2] == (p3 ? timer_three_pulse : port_data[6]); endproperty
    property p_updown; ok |-> timer_three_updown == (i3 & ~ud[6] & $past(pin_in[2], 2)); endproperty
    property p_two_phase; ok |-> timer_three_two_phase == (i3 & ud[6] & $past(pin_in[2], 2)); endproperty
    property p_gate; ok |-> timer_two_gate == (g & m2[4] & $past(pin_in[1], 2)); endproperty
    property p_count; ok |-> timer_two_count_src == (g & $past(pin_in[1], 2)); endproperty
    property p_wphase; tp[2] |-> pin_oe[0] && pin_oe[1] && pin_out[0] == w_phase; endproperty
    property p_pullup; pin_pullup == ({3{pu[7]}} & ~pin_oe); endproperty
    property p_port_in; ok && $changed(pin_in) |-> ##2 port_pin_in == $past(pin_in, 2); endproperty
    a_oe_six: assert property (p_oe_six)
        else $error("bit six drive enable wrong");
    a_out_six: assert property (p_out_six)
        else $error("bit six drive value wrong");
    a_updown: assert property (p_updown)
        else $error("up/down input wrong");
    a_two_phase: assert property (p_two_phase)
        else $error("two-phase input wrong");
    a_gate: assert property (p_gate)
        else $error("gate input wrong");
    a_count: assert property (p_count)
        else $error("count source input wrong");
    a_wphase: assert property (p_wphase)
        else $error("W phase drive wrong");
    a_pullup: assert property (p_pullup)
        else $error("pull-up enable wrong");
    a_port_in: assert property (p_port_in)
        else $error("port input level wrong");
    c_pulse: cover property (p3 && pin_oe[2]);
    c_two: cover property (timer_three_two_phase);
    c_w: cover property (tp[2]);
endmodule // tpfs_top_assertions
bind tpfs_top tpfs_top_assertions u_tpfs_top_assertions (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .port_data(port_data),
    .timer_three_pulse(timer_three_pulse), .w_phase(w_phase), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .timer_three_updown(timer_three_updown), .timer_three_two_phase(timer_three_two_phase),
    .timer_two_gate(timer_two_gate), .timer_two_count_src(timer_two_count_src), .port_pin_in(port_pin_in));

/* File: test/timer_pin_function_select_tb.sv */
// Purpose: Self-checking bench for the pin function select block
// Assumes: Zero-wait APB slave; pins driven by the partner model
// Notes:   Random settings with two fixed corner settings first
`timescale 1ns/1ps
module timer_pin_function_select_tb;
    import tpfs_pkg::*;
    logic        core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext_en = 1'b0;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  port_data = 8'h0;
    logic        timer_two_pulse = 1'b0, timer_three_pulse = 1'b0, w_phase = 1'b0, w_phase_n = 1'b0;
    logic        pready, pslverr, t3u, t3t, t2u, t2t, t2g, t2c, t2r;
    logic [2:0]  pin_in, pin_out, pin_oe, pin_pullup, port_pin_in, ext = 3'h0;
    int          fail_count = 0, n_tests = 0, cyc = 0;
    logic [11:0] idx [7] = '{IDX_THREE_PHASE, IDX_TRIG_SEL, IDX_UPDOWN, IDX_TMR_TWO_MODE, IDX_TMR_THR_MODE,
                             IDX_PORT_DIR, IDX_PULLUP_ONE};
    tpfs_top u_tpfs_top (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_data(port_data),
        .timer_two_pulse(timer_two_pulse), .timer_three_pulse(timer_three_pulse), .w_phase(w_phase),
        .w_phase_n(w_phase_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .timer_three_updown(t3u), .timer_three_two_phase(t3t), .timer_two_updown(t2u), .timer_two_two_phase(t2t),
        .timer_two_gate(t2g), .timer_two_count_src(t2c), .timer_two_trigger(t2r), .port_pin_in(port_pin_in));
    tpfs_pin_model u_tpfs_pin_model (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext(ext), .ext_en(ext_en), .pin_in(pin_in));
    initial forever #25 core_clk = ~core_clk;
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic [11:0] ix, input logic wr, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {ix, 2'b00};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Order: {oe, pullup, pin level, seven timer inputs}; s = {w_n, w, pulse three, pulse two}
    function automatic logic [15:0] expect_pins(logic [55:0] c, logic [7:0] pd, logic [3:0] s, logic [2:0] x);
        logic tp, p3, p2, i3, i2, g;
        logic [2:0] oe, o, pin;
        tp = c[50];
        p3 = c[18] & ~c[38];
        p2 = c[26] & ~c[37];
        oe = {p3 | c[14], tp | c[13], tp | p2 | c[12]};
        o = {p3 ? s[1] : pd[6], tp ? s[3] : pd[5], tp ? s[2] : (p2 ? s[0] : pd[4])};
        pin = (oe & o) | (~oe & x);
        i3 = ~c[14] & c[20] & ~c[18] & pin[2];
        i2 = ~c[12] & ~tp & c[28] & ~c[26] & pin[0];
        g = ~c[13] & ~c[43] & ~c[42] & ~tp & pin[1];
        return {oe, c[7] ? ~oe : 3'h0, pin, i3 & ~c[38], i3 & c[38], i2 & ~c[37], i2 & c[37], g & c[28], g, g & c[28]};
    endfunction
    initial begin
        logic [31:0] rd, wd;
        logic        er;
        logic [55:0] cfg;
        logic [15:0] e;
        void'($urandom(34));
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            apb(idx[k], 1'b0, 32'h0, rd, er);
            chk("reset value", rd, 32'h0);
            wd = $urandom;
            apb(idx[k], 1'b1, wd, rd, er);
            apb(idx[k], 1'b0, 32'h0, rd, er);
            chk("readback", rd, {24'h0, wd[7:0]});
        end
        apb(12'h100, 1'b0, 32'h0, rd, er);
        chk("unmapped read", {rd[30:0], er}, 32'h1);
        $display("register test done");
        for (int i = 0; i < 40; i++) begin
            // Corners: pulse withheld under two-phase; three-phase over pulse and direction
            cfg = i == 0 ? 56'h00006004040080 : (i == 1 ? 56'h040c0014147080 : 56'({$urandom, $urandom}));
            for (int k = 0; k < 7; k++) apb(idx[k], 1'b1, {24'h0, cfg[55-8*k -: 8]}, rd, er);
            port_data <= 8'($urandom);
            {w_phase_n, w_phase, timer_three_pulse, timer_two_pulse} <= 4'($urandom);
            ext <= 3'($urandom);
            ext_en <= 1'b1;
            repeat (3) @(posedge core_clk);
            @(negedge core_clk);
            e = expect_pins(cfg, port_data, {w_phase_n, w_phase, timer_three_pulse, timer_two_pulse}, ext);
            chk("drive enables", {29'h0, pin_oe}, {29'h0, e[15:13]});
            chk("pullup and pins", {26'h0, pin_pullup, port_pin_in}, {26'h0, e[12:7]});
            chk("timer inputs", {25'h0, t3u, t3t, t2u, t2t, t2g, t2c, t2r}, {25'h0, e[6:0]});
            apb(IDX_PIN_STATUS, 1'b0, 32'h0, rd, er);
            chk("pin status", rd, {25'h0, e[15:13], 1'b0, e[9:7]});
        end
        $display("pin function test done");
        tally_and_finish();
    end
endmodule // timer_pin_function_select_tb
